// *** hw/dual_port_block_ram_ops.sv ***
// Dual-port block RAM data path with per-port output latches and APB setup
//
// Notes on behaviour
// - Each port reads and writes on its own port clock, independently.
// - Enable, write enable and preset are active high; rising port clock edges act.
// - Enable and write enable high store write data at the port address.
// - Parity bits are stored and output exactly like the data bits.
// - Enabled edge without write loads the addressed word into the output latch.
// - Write-first mode presents the newly written word on the same port.
// - Read-first mode presents the previous word, then overwrites it.
// - No-change mode holds outputs during a write; memory is still written.
// - Other port's outputs are invalid on a write-first or no-change address clash.
// - Read-first clash gives the other port the word from before the write.
// - Port enable low: no read, no write, outputs and memory unchanged.
// - Preset at an enabled edge loads the preset value, with or without a write.
// - Write mode per port is write-first, read-first or no-change.
`timescale 1ns/1ps
module dual_port_block_ram_ops #(
   parameter int ADDR_W = ram_ops_pkg::ADDR_W
) (
   // System
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic global_reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ram_ops_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [ram_ops_pkg::APB_DATA_W-1:0] pwdata,
   output logic pready,
   output logic [ram_ops_pkg::APB_DATA_W-1:0] prdata,
   output logic pslverr,
   // Port A
   input wire logic port_clk_a,
   input wire logic port_en_a,
   input wire logic port_we_a,
   input wire logic output_sync_preset_a,
   input wire logic [ADDR_W-1:0] port_addr_a,
   input wire logic [ram_ops_pkg::DATA_W-1:0] port_write_data_a,
   input wire logic [ram_ops_pkg::PAR_W-1:0] port_write_parity_a,
   output logic [ram_ops_pkg::DATA_W-1:0] port_read_data_a,
   output logic [ram_ops_pkg::PAR_W-1:0] port_read_parity_a,
   output logic port_read_invalid_a,
   // Port B
   input wire logic port_clk_b,
   input wire logic port_en_b,
   input wire logic port_we_b,
   input wire logic output_sync_preset_b,
   input wire logic [ADDR_W-1:0] port_addr_b,
   input wire logic [ram_ops_pkg::DATA_W-1:0] port_write_data_b,
   input wire logic [ram_ops_pkg::PAR_W-1:0] port_write_parity_b,
   output logic [ram_ops_pkg::DATA_W-1:0] port_read_data_b,
   output logic [ram_ops_pkg::PAR_W-1:0] port_read_parity_b,
   output logic port_read_invalid_b
);
   import ram_ops_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;
   localparam int PORTS = 2;

   typedef logic [WORD_W-1:0] word_t;

   typedef struct packed {
      logic [PORTS-1:0] clk_seen;
      word_t [DEPTH-1:0] mem;
   } ram_state_t;

   // Clock history starts high so a port clock already high at release is no edge
   localparam ram_state_t RAM_RESET = '{clk_seen: '1, mem: '0};

   ram_state_t state;
   ram_state_t next_state;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-port views of the separate ports
   logic [PORTS-1:0] clk_in;
   logic [PORTS-1:0] en_in;
   logic [PORTS-1:0] we_in;
   logic [PORTS-1:0] preset_in;
   logic [PORTS-1:0] fire;
   logic [PORTS-1:0] clash;
   logic [PORTS-1:0] invalid;
   logic [PORTS-1:0][ADDR_W-1:0] addr_in;
   word_t [PORTS-1:0] wr_word;
   word_t [PORTS-1:0] old_word;
   word_t [PORTS-1:0] preset_word;
   word_t [PORTS-1:0] init_word;
   word_t [PORTS-1:0] out_word;
   write_mode_t [PORTS-1:0] mode;

   assign clk_in = {port_clk_b, port_clk_a};
   assign en_in = {port_en_b, port_en_a};
   assign we_in = {port_we_b, port_we_a};
   assign preset_in = {output_sync_preset_b, output_sync_preset_a};
   assign addr_in = {port_addr_b, port_addr_a};
   assign wr_word[0] = {port_write_parity_a, port_write_data_a};
   assign wr_word[1] = {port_write_parity_b, port_write_data_b};

   // A writing port in write-first or no-change spoils a read of the same word
   function automatic logic spoils(input logic w_fire, input logic w_we,
                                   input write_mode_t w_mode,
                                   input logic [ADDR_W-1:0] w_addr,
                                   input logic r_fire,
                                   input logic [ADDR_W-1:0] r_addr);
      return w_fire && w_we && r_fire && (w_addr == r_addr) && (w_mode != READ_FIRST);
   endfunction : spoils

   ////////////////////////////////////////////////////////////////////////////////
   // Port edge detection and output latches
   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_port
         assign fire[p] = en_in[p] && clk_in[p] && !state.clk_seen[p];
         assign old_word[p] = state.mem[addr_in[p]];
         assign clash[p] = spoils(fire[PORTS-1-p], we_in[PORTS-1-p], mode[PORTS-1-p],
                                  addr_in[PORTS-1-p], fire[p], addr_in[p]);

         ram_out_latch u_latch (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .global_reset(global_reset),
            .fire(fire[p]),
            .we(we_in[p]),
            .sync_preset(preset_in[p]),
            .clash(clash[p]),
            .mode(mode[p]),
            .write_word(wr_word[p]),
            .old_word(old_word[p]),
            .preset_word(preset_word[p]),
            .init_word(init_word[p]),
            .out_word(out_word[p]),
            .invalid(invalid[p])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Memory array; on a same-address double write port B lands last
   always_comb begin
      next_state = state;
      if (clk_en) begin
         next_state.clk_seen = clk_in;
         for (int i = 0; i < PORTS; i++) begin
            // preset does not block the write
            if (fire[i] && we_in[i]) begin
               next_state.mem[addr_in[i]] = wr_word[i];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= RAM_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   ram_cfg_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .mode_a(mode[0]),
      .mode_b(mode[1]),
      .preset_word_a(preset_word[0]),
      .preset_word_b(preset_word[1]),
      .init_word_a(init_word[0]),
      .init_word_b(init_word[1]),
      .invalid(invalid)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign port_read_data_a = out_word[0][DATA_W-1:0];
   assign port_read_parity_a = out_word[0][WORD_W-1:DATA_W];
   assign port_read_invalid_a = invalid[0];
   assign port_read_data_b = out_word[1][DATA_W-1:0];
   assign port_read_parity_b = out_word[1][WORD_W-1:DATA_W];
   assign port_read_invalid_b = invalid[1];

endmodule : dual_port_block_ram_ops

// *** include/ram_ops_pkg.sv ***
// Shared constants and types for the dual-port block RAM data path
package ram_ops_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Data path widths
   localparam int DATA_W = 32;
   localparam int PAR_W = 4;
   localparam int WORD_W = DATA_W + PAR_W;
   localparam int ADDR_W = 9;
   localparam int APB_ADDR_W = 8;
   localparam int APB_DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_PRESET_A = 8'h04;
   localparam logic [7:0] OFS_PRESET_B = 8'h08;
   localparam logic [7:0] OFS_PRESET_PAR = 8'h0C;
   localparam logic [7:0] OFS_INIT_A = 8'h10;
   localparam logic [7:0] OFS_INIT_B = 8'h14;
   localparam logic [7:0] OFS_INIT_PAR = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int MODE_A_LSB = 0;
   localparam int MODE_B_LSB = 2;
   localparam int MODE_W = 2;
   localparam int PAR_A_LSB = 0;
   localparam int PAR_B_LSB = 4;
   localparam int STATUS_INVALID_A = 0;
   localparam int STATUS_INVALID_B = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Write mode field codes and reset values
   localparam logic [1:0] MODE_CODE_WRITE_FIRST = 2'h0;
   localparam logic [1:0] MODE_CODE_READ_FIRST = 2'h1;
   localparam logic [1:0] MODE_CODE_NO_CHANGE = 2'h2;
   localparam logic [1:0] MODE_RESET = MODE_CODE_WRITE_FIRST;
   localparam logic [DATA_W-1:0] PRESET_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] INIT_RESET = 32'h0000_0000;
   localparam logic [7:0] PAR_RESET = 8'h00;

   typedef enum logic [1:0] {WRITE_FIRST, READ_FIRST, NO_CHANGE} write_mode_t;

   // Unused code 3 behaves as the reset mode
   function automatic write_mode_t decode_mode(input logic [1:0] code);
      case (code)
         MODE_CODE_READ_FIRST: return READ_FIRST;
         MODE_CODE_NO_CHANGE: return NO_CHANGE;
         default: return WRITE_FIRST;
      endcase
   endfunction : decode_mode

endpackage : ram_ops_pkg

// *** hw/ram_out_latch.sv ***
// Output latch of one RAM port with write mode, preset and init handling
`timescale 1ns/1ps
module ram_out_latch (
   // System
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic global_reset,
   // Port control
   input wire logic fire,
   input wire logic we,
   input wire logic sync_preset,
   input wire logic clash,
   input wire ram_ops_pkg::write_mode_t mode,
   // Words
   input wire logic [ram_ops_pkg::WORD_W-1:0] write_word,
   input wire logic [ram_ops_pkg::WORD_W-1:0] old_word,
   input wire logic [ram_ops_pkg::WORD_W-1:0] preset_word,
   input wire logic [ram_ops_pkg::WORD_W-1:0] init_word,
   // Result
   output logic [ram_ops_pkg::WORD_W-1:0] out_word,
   output logic invalid
);
   import ram_ops_pkg::*;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic invalid;
   } latch_state_t;

   latch_state_t state;
   latch_state_t next_state;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      if (clk_en) begin
         if (global_reset) begin
            next_state.word = init_word;
            next_state.invalid = 1'b0;
         end else if (fire) begin
            next_state.invalid = clash;
            if (sync_preset) begin
               next_state.word = preset_word;
            end else if (!we) begin
               next_state.word = old_word;
            end else begin
               case (mode)
                  WRITE_FIRST: next_state.word = write_word;
                  READ_FIRST: next_state.word = old_word;
                  NO_CHANGE: next_state.word = state.word;
                  default: next_state.word = state.word;
               endcase
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign out_word = state.word;
   assign invalid = state.invalid;

endmodule : ram_out_latch

// *** hw/ram_cfg_regs.sv ***
// APB configuration and status registers of the dual-port RAM
`timescale 1ns/1ps
module ram_cfg_regs (
   // System
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ram_ops_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [ram_ops_pkg::APB_DATA_W-1:0] pwdata,
   output logic pready,
   output logic [ram_ops_pkg::APB_DATA_W-1:0] prdata,
   output logic pslverr,
   // Configuration out
   output ram_ops_pkg::write_mode_t mode_a,
   output ram_ops_pkg::write_mode_t mode_b,
   output logic [ram_ops_pkg::WORD_W-1:0] preset_word_a,
   output logic [ram_ops_pkg::WORD_W-1:0] preset_word_b,
   output logic [ram_ops_pkg::WORD_W-1:0] init_word_a,
   output logic [ram_ops_pkg::WORD_W-1:0] init_word_b,
   // Status in
   input wire logic [1:0] invalid
);
   import ram_ops_pkg::*;

   typedef struct packed {
      logic [3:0] mode;
      logic [DATA_W-1:0] preset_a;
      logic [DATA_W-1:0] preset_b;
      logic [7:0] preset_par;
      logic [DATA_W-1:0] init_a;
      logic [DATA_W-1:0] init_b;
      logic [7:0] init_par;
      logic [APB_DATA_W-1:0] rdata;
      logic slverr;
   } regs_state_t;

   localparam regs_state_t REGS_RESET = '{
      mode: {MODE_RESET, MODE_RESET},
      preset_a: PRESET_RESET, preset_b: PRESET_RESET, preset_par: PAR_RESET,
      init_a: INIT_RESET, init_b: INIT_RESET, init_par: PAR_RESET,
      rdata: '0, slverr: 1'b0};

   regs_state_t state;
   regs_state_t next_state;

   function automatic logic is_mapped(input logic [APB_ADDR_W-1:0] a);
      case (a)
         OFS_MODE, OFS_PRESET_A, OFS_PRESET_B, OFS_PRESET_PAR,
         OFS_INIT_A, OFS_INIT_B, OFS_INIT_PAR, OFS_STATUS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_mapped

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      if (clk_en && psel && !penable) begin
         // Setup phase: capture read data and error for the access phase
         next_state.slverr = !is_mapped(paddr);
         next_state.rdata = '0;
         if (!pwrite) begin
            case (paddr)
               OFS_MODE: next_state.rdata = {28'h0000000, state.mode};
               OFS_PRESET_A: next_state.rdata = state.preset_a;
               OFS_PRESET_B: next_state.rdata = state.preset_b;
               OFS_PRESET_PAR: next_state.rdata = {24'h000000, state.preset_par};
               OFS_INIT_A: next_state.rdata = state.init_a;
               OFS_INIT_B: next_state.rdata = state.init_b;
               OFS_INIT_PAR: next_state.rdata = {24'h000000, state.init_par};
               OFS_STATUS: next_state.rdata = {30'h0, invalid};
               default: next_state.rdata = '0;
            endcase
         end
      end
      if (clk_en && psel && penable && pwrite) begin
         case (paddr)
            OFS_MODE: next_state.mode = pwdata[3:0];
            OFS_PRESET_A: next_state.preset_a = pwdata;
            OFS_PRESET_B: next_state.preset_b = pwdata;
            OFS_PRESET_PAR: next_state.preset_par = pwdata[7:0];
            OFS_INIT_A: next_state.init_a = pwdata;
            OFS_INIT_B: next_state.init_b = pwdata;
            OFS_INIT_PAR: next_state.init_par = pwdata[7:0];
            default: next_state.mode = state.mode;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= REGS_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Zero wait states; a frozen clock enable stalls the access
   assign pready = clk_en;
   assign prdata = state.rdata;
   assign pslverr = state.slverr;
   assign mode_a = decode_mode(state.mode[MODE_A_LSB +: MODE_W]);
   assign mode_b = decode_mode(state.mode[MODE_B_LSB +: MODE_W]);
   assign preset_word_a = {state.preset_par[PAR_A_LSB +: PAR_W], state.preset_a};
   assign preset_word_b = {state.preset_par[PAR_B_LSB +: PAR_W], state.preset_b};
   assign init_word_a = {state.init_par[PAR_A_LSB +: PAR_W], state.init_a};
   assign init_word_b = {state.init_par[PAR_B_LSB +: PAR_W], state.init_b};

endmodule : ram_cfg_regs

// *** dv/ram_ops_sva.sv ***
// Assertion checker for the dual-port block RAM data path
`timescale 1ns/1ps
module ram_ops_sva import ram_ops_pkg::*; #(
   parameter int ADDR_W = 9
) (
   // System
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic global_reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic [APB_DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic [APB_DATA_W-1:0] prdata,
   input wire logic pslverr,
   // Port A
   input wire logic port_clk_a,
   input wire logic port_en_a,
   input wire logic port_we_a,
   input wire logic output_sync_preset_a,
   input wire logic [ADDR_W-1:0] port_addr_a,
   input wire logic [DATA_W-1:0] port_write_data_a,
   input wire logic [PAR_W-1:0] port_write_parity_a,
   input wire logic [DATA_W-1:0] port_read_data_a,
   input wire logic [PAR_W-1:0] port_read_parity_a,
   input wire logic port_read_invalid_a,
   // Port B
   input wire logic port_clk_b,
   input wire logic port_en_b,
   input wire logic port_we_b,
   input wire logic output_sync_preset_b,
   input wire logic [ADDR_W-1:0] port_addr_b,
   input wire logic [DATA_W-1:0] port_read_data_b,
   input wire logic [PAR_W-1:0] port_read_parity_b,
   input wire logic port_read_invalid_b
);
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of port clock history, mode and preset A
   logic [1:0] hist;
   logic [3:0] mode_q;
   logic [35:0] pre_a;
   wire apb_wr = psel && penable && pready && pwrite;
   wire fire_a = clk_en && port_en_a && port_clk_a && !hist[0];
   wire fire_b = clk_en && port_en_b && port_clk_b && !hist[1];
   wire wr_a = fire_a && port_we_a && !output_sync_preset_a && !global_reset;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist <= 2'h3;
         mode_q <= 4'h0;
         pre_a <= 36'h0;
      end else if (clk_en) begin
         hist <= {port_clk_b, port_clk_a};
         if (apb_wr && paddr == OFS_MODE) mode_q <= pwdata[3:0];
         if (apb_wr && paddr == OFS_PRESET_A) pre_a[31:0] <= pwdata;
         if (apb_wr && paddr == OFS_PRESET_PAR) pre_a[35:32] <= pwdata[3:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_follows: assert property (pready == clk_en)
      else $error("pready differs from clk_en");
   a_bad_offset: assert property (psel && !penable && clk_en && paddr > 8'h1F
      |=> pslverr && prdata == 32'h0) else $error("unmapped offset not refused");
   a_wf_new_a: assert property (wr_a && (mode_q[1:0] == 2'h0 || mode_q[1:0] == 2'h3)
      |=> {port_read_parity_a, port_read_data_a} ==
      $past({port_write_parity_a, port_write_data_a})) else $error("new word not shown");
   a_nc_hold_a: assert property (wr_a && mode_q[1:0] == 2'h2
      |=> $stable({port_read_parity_a, port_read_data_a})) else $error("output not held");
   a_preset_a: assert property (fire_a && output_sync_preset_a && !global_reset
      |=> {port_read_parity_a, port_read_data_a} == $past(pre_a)) else $error("no preset");
   a_idle_b: assert property (clk_en && !port_en_b && !global_reset
      |=> $stable(port_read_data_b) && $stable(port_read_parity_b))
      else $error("disabled port changed");
   a_init_valid: assert property (clk_en && global_reset
      |=> !port_read_invalid_a && !port_read_invalid_b) else $error("invalid not cleared");
   a_clash_flag_b: assert property (wr_a && mode_q[1:0] != 2'h1 && fire_b
      && !port_we_b && !output_sync_preset_b && port_addr_a == port_addr_b
      |=> port_read_invalid_b) else $error("clash not flagged");
   c_write_a: cover property (wr_a);
   c_both_fire: cover property (fire_a && fire_b);
   c_init: cover property (clk_en && global_reset);
endmodule : ram_ops_sva

bind dual_port_block_ram_ops ram_ops_sva #(.ADDR_W(ADDR_W)) u_sva (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .global_reset(global_reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .port_clk_a(port_clk_a), .port_en_a(port_en_a), .port_we_a(port_we_a),
   .output_sync_preset_a(output_sync_preset_a), .port_addr_a(port_addr_a),
   .port_write_data_a(port_write_data_a), .port_write_parity_a(port_write_parity_a),
   .port_read_data_a(port_read_data_a), .port_read_parity_a(port_read_parity_a),
   .port_read_invalid_a(port_read_invalid_a), .port_clk_b(port_clk_b),
   .port_en_b(port_en_b), .port_we_b(port_we_b), .output_sync_preset_b(output_sync_preset_b),
   .port_addr_b(port_addr_b), .port_read_data_b(port_read_data_b),
   .port_read_parity_b(port_read_parity_b), .port_read_invalid_b(port_read_invalid_b)
);

// *** dv/port_driver.sv ***
// User logic model that drives one RAM port
`timescale 1ns/1ps
module port_driver #(
   parameter int ADDR_W = 9
) (
   // Clock
   input wire logic pclk,
   // Port pins
   output logic port_clk,
   output logic en,
   output logic we,
   output logic preset,
   output logic [ADDR_W-1:0] addr,
   output logic [31:0] wdata,
   output logic [3:0] wpar
);
   int gap = 0;
   initial begin
      port_clk = 1'b0;
      {en, we, preset} = 3'h0;
      addr = '0;
      {wpar, wdata} = 36'h0;
   end
   task automatic op(input logic e, w, s, input logic [ADDR_W-1:0] a, input logic [35:0] d);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      port_clk <= 1'b1;
      {en, we, preset} <= {e, w, s};
      addr <= a;
      {wpar, wdata} <= d;
      @(posedge pclk);
      // Released lines show garbage, not the last value
      port_clk <= 1'b0;
      {en, we, preset} <= 3'h0;
      addr <= ~a;
      {wpar, wdata} <= ~d;
      @(negedge pclk);
   endtask : op
endmodule : port_driver

// *** dv/tb_top.sv ***
// Self-checking bench for the dual-port block RAM data path
`timescale 1ns/1ps
module tb_top;
   import ram_ops_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic global_reset = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, ck_a, en_a, we_a, sr_a, ck_b, en_b, we_b, sr_b, inv_a, inv_b;
   logic [31:0] prdata, wd_a, wd_b, rd_a, rd_b;
   logic [8:0] ad_a, ad_b;
   logic [3:0] wp_a, wp_b, rp_a, rp_b;
   logic [35:0] old8, nw, exp;
   int error_cnt = 0;
   int n_checks = 0;
   always #2 pclk = ~pclk;
   dual_port_block_ram_ops dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .global_reset(global_reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .port_clk_a(ck_a), .port_en_a(en_a), .port_we_a(we_a), .output_sync_preset_a(sr_a),
      .port_addr_a(ad_a), .port_write_data_a(wd_a), .port_write_parity_a(wp_a),
      .port_read_data_a(rd_a), .port_read_parity_a(rp_a), .port_read_invalid_a(inv_a),
      .port_clk_b(ck_b), .port_en_b(en_b), .port_we_b(we_b), .output_sync_preset_b(sr_b),
      .port_addr_b(ad_b), .port_write_data_b(wd_b), .port_write_parity_b(wp_b),
      .port_read_data_b(rd_b), .port_read_parity_b(rp_b), .port_read_invalid_b(inv_b)
   );
   port_driver pa (.pclk(pclk), .port_clk(ck_a), .en(en_a), .we(we_a), .preset(sr_a),
      .addr(ad_a), .wdata(wd_a), .wpar(wp_a));
   port_driver pb (.pclk(pclk), .port_clk(ck_b), .en(en_b), .we(we_b), .preset(sr_b),
      .addr(ad_b), .wdata(wd_b), .wpar(wp_b));
   ////////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic results();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [35:0] seen, input logic [35:0] expv);
      n_checks++;
      if (seen !== expv) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         results();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic err;
      apb(1'b1, a, d, q, err);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] expv, input logic experr);
      logic [31:0] q;
      logic err;
      apb(1'b0, a, 32'h0, q, err);
      chk({4'h0, q}, {4'h0, expv});
      chk({35'h0, err}, {35'h0, experr});
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      rd(OFS_STATUS, 32'h0, 1'b0);
      wr(OFS_PRESET_A, 32'hA5A5_0001);
      wr(OFS_PRESET_PAR, 32'h6C);
      wr(OFS_INIT_A, 32'h1111_2222);
      wr(OFS_INIT_B, 32'h3333_4444);
      wr(OFS_INIT_PAR, 32'h39);
      rd(OFS_PRESET_PAR, 32'h6C, 1'b0);
      @(posedge pclk);
      global_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      global_reset <= 1'b0;
      @(negedge pclk);
      chk({rp_a, rd_a}, 36'h9_1111_2222);
      chk({rp_b, rd_b}, 36'h3_3333_4444);
      pa.op(1'b1, 1'b1, 1'b0, 9'h009, 36'h9_0909_0909);
      chk({rp_a, rd_a}, 36'h9_0909_0909);
      pb.op(1'b1, 1'b0, 1'b0, 9'h009, 36'h0);
      chk({rp_b, rd_b}, 36'h9_0909_0909);
      pa.op(1'b1, 1'b1, 1'b0, 9'h008, 36'h8_0808_0808);
      old8 = 36'h8_0808_0808;
      for (int c = 0; c < 4; c++) begin
         wr(OFS_MODE, 32'(c));
         pa.gap = c;
         pa.op(1'b1, 1'b0, 1'b0, 9'h009, 36'h0);
         chk({rp_a, rd_a}, 36'h9_0909_0909);
         nw = {4'(c + 1), 32'hC0DE_0000 + 32'(c)};
         pa.op(1'b1, 1'b1, 1'b0, 9'h008, nw);
         exp = (c == 1) ? old8 : (c == 2) ? 36'h9_0909_0909 : nw;
         chk({rp_a, rd_a}, exp);
         pa.op(1'b1, 1'b0, 1'b0, 9'h008, 36'h0);
         chk({rp_a, rd_a}, nw);
         old8 = nw;
      end
      pa.gap = 0;
      pa.op(1'b1, 1'b0, 1'b1, 9'h008, 36'h0);
      chk({rp_a, rd_a}, 36'hC_A5A5_0001);
      pa.op(1'b1, 1'b0, 1'b0, 9'h008, 36'h0);
      chk({rp_a, rd_a}, old8);
      pa.op(1'b1, 1'b1, 1'b1, 9'h008, 36'h5_5555_AAAA);
      chk({rp_a, rd_a}, 36'hC_A5A5_0001);
      pa.op(1'b1, 1'b0, 1'b0, 9'h008, 36'h0);
      chk({rp_a, rd_a}, 36'h5_5555_AAAA);
      pa.op(1'b0, 1'b1, 1'b0, 9'h008, 36'hF_FFFF_FFFF);
      chk({rp_a, rd_a}, 36'h5_5555_AAAA);
      pa.op(1'b1, 1'b0, 1'b0, 9'h008, 36'h0);
      chk({rp_a, rd_a}, 36'h5_5555_AAAA);
      // Frozen clock enable: no preset, no write
      @(posedge pclk);
      clk_en <= 1'b0;
      pa.op(1'b1, 1'b1, 1'b1, 9'h008, 36'h0);
      chk({rp_a, rd_a}, 36'h5_5555_AAAA);
      @(posedge pclk);
      clk_en <= 1'b1;
      pa.op(1'b1, 1'b0, 1'b0, 9'h008, 36'h0);
      chk({rp_a, rd_a}, 36'h5_5555_AAAA);
      // data of port B is not relied on during a write-first clash
      wr(OFS_MODE, 32'h0);
      fork
         pa.op(1'b1, 1'b1, 1'b0, 9'h00C, 36'h4_4444_0004);
         pb.op(1'b1, 1'b0, 1'b0, 9'h00C, 36'h0);
      join
      chk({35'h0, inv_b}, 36'h1);
      rd(OFS_STATUS, 32'h2, 1'b0);
      wr(OFS_MODE, 32'h1);
      fork
         pa.op(1'b1, 1'b1, 1'b0, 9'h00C, 36'h7_7777_0005);
         pb.op(1'b1, 1'b0, 1'b0, 9'h00C, 36'h0);
      join
      chk({rp_b, rd_b}, 36'h4_4444_0004);
      chk({35'h0, inv_b}, 36'h0);
      wr(OFS_MODE, 32'h8);
      pb.op(1'b1, 1'b1, 1'b0, 9'h014, 36'h6_0000_6666);
      chk({rp_b, rd_b}, 36'h4_4444_0004);
      pa.op(1'b1, 1'b0, 1'b0, 9'h014, 36'h0);
      chk({rp_a, rd_a}, 36'h6_0000_6666);
      results();
   end
endmodule : tb_top
